// ==== src/capture_pkg.sv ====
// constants, register map and carrier types of the servo signal capture unit
// assumes a 32-bit ahb-lite fabric with byte registers in the low lane of each word
// Functional notes
// - each of eight trigger sources has enable
// - track divider: six-bit ratio, zero passes through
// - manual duty sampling tap, used when not automatic
// - remote counter runs on start, clears on stop
// - remote polarity and noise canceller bypass
// - drum speed divider: three-bit ratio
// - drum divider clear is one-shot write
// - track and capstan polarity selects
// - per input edge choice as listed
// - capstan prescale then six-bit divider
// - separator counter ticks on tap one or two
// - vertical sync mask release is one-shot
// - duty polarity bit (stored, no effect) and automatic clock choice
// - track divider bypass, capstan input gate
// - index value against counter upper four bits
// - eight-entry buffer with per-entry present bits
// - eighteen-bit stamp over three bytes
// - high byte upper six: accepted triggers
// - two sixteen-bit read-only timestamps
// - clear register with one-shot clears, status
package capture_pkg;

  // ****************************************
  // register indices (byte address is four times)
  // ****************************************
  localparam int IDX_W = 8;
  localparam logic [IDX_W-1:0] IDX_SRC_EN = 8'h46;
  localparam logic [IDX_W-1:0] IDX_TRACK_DIV = 8'h47;
  localparam logic [IDX_W-1:0] IDX_REMOTE_DRUM = 8'h48;
  localparam logic [IDX_W-1:0] IDX_EDGE_POL = 8'h49;
  localparam logic [IDX_W-1:0] IDX_FIFO_STAT = 8'h4a;
  localparam logic [IDX_W-1:0] IDX_FIFO_LOW = 8'h4b;
  localparam logic [IDX_W-1:0] IDX_FIFO_MID = 8'h4c;
  localparam logic [IDX_W-1:0] IDX_FIFO_HIGH = 8'h4d;
  localparam logic [IDX_W-1:0] IDX_CAP1_LOW = 8'h4e;
  localparam logic [IDX_W-1:0] IDX_CAP1_HIGH = 8'h4f;
  localparam logic [IDX_W-1:0] IDX_CAP2_LOW = 8'h50;
  localparam logic [IDX_W-1:0] IDX_CAP2_HIGH = 8'h51;
  localparam logic [IDX_W-1:0] IDX_CLEAR = 8'h52;
  localparam logic [IDX_W-1:0] IDX_DUTY_CTRL = 8'h55;
  localparam logic [IDX_W-1:0] IDX_SYNC_CTRL = 8'h57;
  localparam logic [IDX_W-1:0] IDX_EXT_CAP_DIV = 8'h68;
  localparam logic [7:0] REG_RESET = 8'h00;

  // ****************************************
  // buffer and counter sizes
  // ****************************************
  localparam int FIFO_DEPTH = 8;
  localparam int PTR_W = 3;
  localparam int STAMP_W = 18;
  localparam logic [6:0] SEP_LOAD = 7'h7f;
  localparam logic [3:0] FIFO_FULL = 4'h8;

  // ****************************************
  // register layouts, msb first
  // ****************************************
  typedef struct packed {
    logic capstan, drum_speed, drum_phase, outside, track, vsync, remote_fall, remote_rise;
  } src_en_t;
  typedef struct packed {
    logic [1:0] duty_sampling_clock_select;
    logic [5:0] track_divide_ratio;
  } track_div_t;
  typedef struct packed {
    logic rsv, remote_run_bit, remote_polarity, remote_noise_bypass, capstan_error_flag;
    logic [2:0] drum_speed_divide_ratio;
  } remote_drum_t;
  typedef struct packed {
    logic drum_divider_reset, track_polarity, capstan_polarity, drum_phase_edge;
    logic drum_speed_edge, capstan_prescale, capstan_edge, track_edge;
  } edge_pol_t;
  typedef struct packed {
    logic duty_polarity, auto_duty_clock, track_divider_bypass, capstan_input_gate;
    logic [3:0] index_compare_value;
  } duty_ctrl_t;
  typedef struct packed {
    logic [1:0] rsv;
    logic drum_phase_seen, composite_sync_polarity, separator_clock_select;
    logic composite_sync_bypass, rsv0, mask_release;
  } sync_ctrl_t;
  typedef struct packed {
    logic outside_trigger_edge, rsv;
    logic [5:0] capstan_divide_ratio;
  } ext_cap_div_t;
  typedef struct packed {
    logic cap2_stat, cap1_stat, cap12_clear;
    logic [2:0] rsv;
    logic capstan_clear, fifo_clear_bit;
  } clear_t;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic capstan, drum_speed, drum_phase, track, outside, remote_input, csync;
  } pins_t;
  typedef struct packed {
    logic tap7, tap3, tap2, tap1;
  } taps_t;
  typedef struct packed {
    logic [5:0] fifo_trigger_status;
    logic [STAMP_W-1:0] stamp;
  } fifo_entry_t;

endpackage

// ==== src/servo_signal_capture_unit.sv ====
// servo signal capture unit: pulse conditioning, capture buffer and ahb-lite slave
// assumes pins are asynchronous, time base and taps come from logic on hclk
`timescale 1ns/1ns

// ****************************************
// ratio divider, ratio n passes every (n+1)th pulse
// ****************************************
module pulse_divider #(
  parameter int W = 6
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clear,
  input wire logic [W-1:0] ratio,
  input wire logic pulse_in,
  output logic pulse_out
);
  logic [W-1:0] cnt_q;
  wire wrap = (cnt_q >= ratio);

  // ratio zero wraps every pulse, so the input passes undivided
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) cnt_q <= '0;
    else if (clear) cnt_q <= '0;
    else if (pulse_in) cnt_q <= wrap ? '0 : cnt_q + 1'b1;
  end
  assign pulse_out = pulse_in & wrap;
endmodule

module servo_signal_capture_unit
  import capture_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire pins_t pins,
  input wire taps_t taps,
  input wire logic [STAMP_W-1:0] time_base,
  output logic duty_sample_strobe,
  output logic index_match,
  output logic [7:0] remote_count
);

  // ****************************************
  // registers
  // ****************************************
  src_en_t en_q;
  track_div_t tdiv_q;
  remote_drum_t rd_q;
  edge_pol_t ep_q;
  duty_ctrl_t dc_q;
  sync_ctrl_t sc_q;
  ext_cap_div_t xc_q;
  logic cap_err_q, seen_q, cap1_st_q, cap2_st_q, vs_mask_q;
  logic [15:0] cap1_q, cap2_q;
  logic [IDX_W-1:0] idx_q;
  logic wr_q;
  logic [7:0] rdata_q;

  // ****************************************
  // bus decode
  // ****************************************
  wire acc = hsel & htrans[1] & hready;
  wire mapped = (haddr[31:IDX_W+2] == '0);
  wire [IDX_W-1:0] idx = haddr[IDX_W+1:2];
  wire rd_go = acc & ~hwrite;
  wire [7:0] wd = hwdata[7:0];
  wire wr_en = wr_q & (idx_q == IDX_SRC_EN);
  wire wr_tdiv = wr_q & (idx_q == IDX_TRACK_DIV);
  wire wr_rd = wr_q & (idx_q == IDX_REMOTE_DRUM);
  wire wr_ep = wr_q & (idx_q == IDX_EDGE_POL);
  wire wr_dc = wr_q & (idx_q == IDX_DUTY_CTRL);
  wire wr_sc = wr_q & (idx_q == IDX_SYNC_CTRL);
  wire wr_xc = wr_q & (idx_q == IDX_EXT_CAP_DIV);
  wire wr_clr = wr_q & (idx_q == IDX_CLEAR);
  wire clear_t cw = clear_t'(wd);
  // named views of the write byte, since a cast cannot be member-selected directly
  wire edge_pol_t ep_w = edge_pol_t'(wd);
  wire sync_ctrl_t sc_w = sync_ctrl_t'(wd);
  wire drum_clr = wr_ep & ep_w.drum_divider_reset;
  wire seen_rst = wr_sc & sc_w.drum_phase_seen;
  wire mask_rel = wr_sc & sc_w.mask_release;
  wire fifo_clr = wr_clr & cw.fifo_clear_bit;
  wire cap12_clr = wr_clr & cw.cap12_clear;
  wire capstan_clr = wr_clr & cw.capstan_clear;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = {24'h000000, rdata_q};

  // address phase is latched; writes land in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      idx_q <= '0;
    end else begin
      wr_q <= acc & hwrite & mapped;
      idx_q <= idx;
    end
  end

  // plain configuration registers; one-shot bits are never stored
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      en_q <= src_en_t'(REG_RESET);
      tdiv_q <= track_div_t'(REG_RESET);
      rd_q <= remote_drum_t'(REG_RESET);
      ep_q <= edge_pol_t'(REG_RESET);
      dc_q <= duty_ctrl_t'(REG_RESET);
      sc_q <= sync_ctrl_t'(REG_RESET);
      xc_q <= ext_cap_div_t'(REG_RESET);
    end else begin
      if (wr_en) en_q <= src_en_t'(wd);
      if (wr_tdiv) tdiv_q <= track_div_t'(wd);
      if (wr_rd) rd_q <= remote_drum_t'(wd & 8'h77);
      if (wr_ep) ep_q <= edge_pol_t'(wd & 8'h7f);
      if (wr_dc) dc_q <= duty_ctrl_t'(wd);
      if (wr_sc) sc_q <= sync_ctrl_t'(wd & 8'h1c);
      if (wr_xc) xc_q <= ext_cap_div_t'(wd & 8'hbf);
    end
  end

  // ****************************************
  // pin synchronisers and edges
  // ****************************************
  logic [6:0] meta_q, pin_q, prev_q;
  pins_t ps;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_q <= '0;
      pin_q <= '0;
    end else begin
      meta_q <= pins;
      pin_q <= meta_q;
    end
  end
  assign ps = pins_t'(pin_q);

  // polarity applied before edge detection
  pins_t cond;
  logic rm_f1_q, rm_f2_q, rm_filt_q;
  always_comb begin
    cond = ps;
    cond.track = ps.track ^ ep_q.track_polarity;
    cond.capstan = (ps.capstan ^ ep_q.capstan_polarity) & dc_q.capstan_input_gate;
    cond.remote_input = (rd_q.remote_noise_bypass ? ps.remote_input : rm_filt_q)
                        ^ rd_q.remote_polarity;
    cond.csync = ps.csync ^ sc_q.composite_sync_polarity;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) prev_q <= '0;
    else prev_q <= cond;
  end
  wire pins_t rise = pins_t'(cond & ~prev_q);
  wire pins_t fall = pins_t'(~cond & prev_q);
  wire pins_t both = pins_t'(rise | fall);

  // ****************************************
  // remote input: noise canceller and run counter
  // ****************************************
  // the canceller needs three equal samples, trading latency for glitch immunity
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rm_f1_q <= 1'b0;
      rm_f2_q <= 1'b0;
      rm_filt_q <= 1'b0;
    end else begin
      rm_f1_q <= ps.remote_input;
      rm_f2_q <= rm_f1_q;
      if (ps.remote_input == rm_f1_q && rm_f1_q == rm_f2_q) rm_filt_q <= rm_f2_q;
    end
  end
  // counter measures time between remote edges while running
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) remote_count <= '0;
    else if (!rd_q.remote_run_bit || both.remote_input) remote_count <= '0;
    else remote_count <= remote_count + 8'h01;
  end

  // ****************************************
  // pulse shaping per source
  // ****************************************
  logic cap_pre_q, cap_div, drum_div, trk_div;
  wire cap_edge = ep_q.capstan_edge ? rise.capstan : both.capstan;
  wire ds_edge = ep_q.drum_speed_edge ? fall.drum_speed : rise.drum_speed;
  wire dp_edge = ep_q.drum_phase_edge ? both.drum_phase : rise.drum_phase;
  wire trk_edge = ep_q.track_edge ? both.track : rise.track;
  wire ext_edge = xc_q.outside_trigger_edge ? both.outside : rise.outside;
  wire cap_pre = cap_edge & (~ep_q.capstan_prescale | cap_pre_q);

  // prescale keeps every second capstan pulse when selected
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) cap_pre_q <= 1'b0;
    else if (cap_edge && ep_q.capstan_prescale) cap_pre_q <= ~cap_pre_q;
  end

  pulse_divider #(.W(6)) capstan_div (
    .hclk(hclk), .hresetn(hresetn), .clear(1'b0),
    .ratio(xc_q.capstan_divide_ratio), .pulse_in(cap_pre), .pulse_out(cap_div));
  pulse_divider #(.W(3)) drum_div_u (
    .hclk(hclk), .hresetn(hresetn), .clear(drum_clr),
    .ratio(rd_q.drum_speed_divide_ratio), .pulse_in(ds_edge), .pulse_out(drum_div));
  pulse_divider #(.W(6)) track_div_u (
    .hclk(hclk), .hresetn(hresetn), .clear(1'b0),
    .ratio(tdiv_q.track_divide_ratio), .pulse_in(trk_edge), .pulse_out(trk_div));
  wire trk_pulse = dc_q.track_divider_bypass ? trk_edge : trk_div;

  // ****************************************
  // control track counter, index match, duty clock
  // ****************************************
  logic [5:0] trk_cnt_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trk_cnt_q <= '0;
      index_match <= 1'b0;
    end else begin
      if (trk_pulse) trk_cnt_q <= trk_cnt_q + 6'h01;
      index_match <= trk_pulse & (trk_cnt_q[5:2] == dc_q.index_compare_value);
    end
  end
  // automatic choice takes the slow tap whenever the track divide ratio is nonzero, even with the divider bypassed
  wire auto_tap7 = (tdiv_q.track_divide_ratio != '0);
  wire man_tap7 = tdiv_q.duty_sampling_clock_select[1];
  wire use_tap7 = dc_q.auto_duty_clock ? auto_tap7 : man_tap7;
  assign duty_sample_strobe = use_tap7 ? taps.tap7 : taps.tap3;

  // ****************************************
  // composite sync separator and masking
  // ****************************************
  logic [6:0] sep_q;
  logic vs_sep_q;
  wire sep_tick = sc_q.separator_clock_select ? taps.tap2 : taps.tap1;
  // a long enough assertion counts down to zero and marks vertical sync
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sep_q <= SEP_LOAD;
      vs_sep_q <= 1'b0;
    end else if (!cond.csync) begin
      sep_q <= SEP_LOAD;
      vs_sep_q <= 1'b0;
    end else if (sep_tick) begin
      if (sep_q == '0) vs_sep_q <= 1'b1;
      else sep_q <= sep_q - 7'h01;
    end
  end
  logic vs_sep_prev_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) vs_sep_prev_q <= 1'b0;
    else vs_sep_prev_q <= vs_sep_q;
  end
  wire vs_edge = sc_q.composite_sync_bypass ? rise.csync : (vs_sep_q & ~vs_sep_prev_q);

  // ****************************************
  // trigger gating
  // ****************************************
  wire [5:0] fifo_trig = {dp_edge & en_q.drum_phase, ext_edge & en_q.outside,
                          trk_pulse & en_q.track, vs_edge & en_q.vsync & ~vs_mask_q,
                          fall.remote_input & en_q.remote_fall & rd_q.remote_run_bit,
                          rise.remote_input & en_q.remote_rise & rd_q.remote_run_bit};
  wire cap2_take = cap_div & en_q.capstan;
  wire cap1_take = drum_div & en_q.drum_speed;

  // status flags: hardware set wins over a software clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      seen_q <= 1'b0;
      vs_mask_q <= 1'b0;
      cap1_st_q <= 1'b0;
      cap2_st_q <= 1'b0;
      cap_err_q <= 1'b0;
      cap1_q <= '0;
      cap2_q <= '0;
    end else begin
      seen_q <= rise.drum_phase | (seen_q & ~seen_rst);
      vs_mask_q <= fifo_trig[2] | (vs_mask_q & ~mask_rel);
      cap1_st_q <= cap1_take | (cap1_st_q & ~cap12_clr);
      cap2_st_q <= cap2_take | (cap2_st_q & ~cap12_clr);
      cap_err_q <= (cap2_take & cap2_st_q) | (cap_err_q & ~capstan_clr);
      if (cap1_take) cap1_q <= time_base[15:0];
      if (cap2_take) cap2_q <= time_base[15:0];
    end
  end

  // ****************************************
  // capture-0 buffer
  // ****************************************
  fifo_entry_t mem [FIFO_DEPTH];
  logic [PTR_W-1:0] wp_q, rp_q;
  logic [3:0] cnt_q;
  logic [7:0] occ;
  wire rd_high = rd_go & mapped & (idx == IDX_FIFO_HIGH);
  wire pop = rd_high & (cnt_q != '0);
  wire push = (|fifo_trig) & (cnt_q != FIFO_FULL) & ~fifo_clr; // a full buffer drops
  wire fifo_entry_t head = (cnt_q != '0) ? mem[rp_q] : '0;

  always_ff @(posedge hclk) begin
    if (push) mem[wp_q] <= '{fifo_trigger_status: fifo_trig, stamp: time_base};
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else if (fifo_clr) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wp_q <= wp_q + 3'h1;
      if (pop) rp_q <= rp_q + 3'h1;
      cnt_q <= cnt_q + {3'h0, push} - {3'h0, pop};
    end
  end
  always_comb begin
    for (int i = 0; i < FIFO_DEPTH; i++) occ[i] = (cnt_q > 4'(i));
  end

  // ****************************************
  // read data
  // ****************************************
  wire remote_drum_t rd_view = '{rsv: 1'b0, remote_run_bit: rd_q.remote_run_bit,
    remote_polarity: rd_q.remote_polarity, remote_noise_bypass: rd_q.remote_noise_bypass,
    capstan_error_flag: cap_err_q, drum_speed_divide_ratio: rd_q.drum_speed_divide_ratio};
  wire [7:0] sc_view = {2'b00, seen_q, sc_q.composite_sync_polarity,
                        sc_q.separator_clock_select, sc_q.composite_sync_bypass, 2'b00};
  logic [7:0] rmux;
  // data is sampled in the address phase so it stands in a zero-wait data phase
  always_comb begin
    case (idx)
      IDX_SRC_EN: rmux = en_q;
      IDX_TRACK_DIV: rmux = tdiv_q;
      IDX_REMOTE_DRUM: rmux = rd_view;
      IDX_EDGE_POL: rmux = ep_q;
      IDX_FIFO_STAT: rmux = occ;
      IDX_FIFO_LOW: rmux = head.stamp[7:0];
      IDX_FIFO_MID: rmux = head.stamp[15:8];
      IDX_FIFO_HIGH: rmux = {head.fifo_trigger_status, head.stamp[17:16]};
      IDX_CAP1_LOW: rmux = cap1_q[7:0];
      IDX_CAP1_HIGH: rmux = cap1_q[15:8];
      IDX_CAP2_LOW: rmux = cap2_q[7:0];
      IDX_CAP2_HIGH: rmux = cap2_q[15:8];
      IDX_CLEAR: rmux = {cap2_st_q, cap1_st_q, 6'h00};
      IDX_DUTY_CTRL: rmux = dc_q;
      IDX_SYNC_CTRL: rmux = sc_view;
      IDX_EXT_CAP_DIV: rmux = xc_q;
      default: rmux = 8'h00;
    endcase
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) rdata_q <= 8'h00;
    else if (rd_go) rdata_q <= mapped ? rmux : 8'h00;
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  AST_SRC_GATED: assert property (push |=>
    (mem[$past(wp_q)].fifo_trigger_status & ~$past(en_q[5:0])) == 6'h00)
    else $error("disabled source reached buffer");
  AST_REMOTE_STOP: assert property (!rd_q.remote_run_bit |=> remote_count == 8'h00)
    else $error("remote counter runs while stopped");
  AST_DRUM_CLEAR: assert property (drum_clr |=> drum_div_u.cnt_q == 3'h0)
    else $error("drum divider not cleared");
  AST_PHASE_SEEN: assert property (rise.drum_phase |=> seen_q)
    else $error("drum phase monitor lost");
  AST_FIFO_GROW: assert property (push & ~pop |=> cnt_q == $past(cnt_q) + 4'h1)
    else $error("buffer count wrong on push");
  AST_FIFO_ORDER: assert property (pop & ~push & ~fifo_clr |=> rp_q == $past(rp_q) + 3'h1 &&
    cnt_q == $past(cnt_q) - 4'h1) else $error("buffer pop out of order");
  AST_CAP1_STAMP: assert property (cap1_take |=> cap1_q == $past(time_base[15:0]))
    else $error("capture one stamp wrong");
  AST_FIFO_CLEAR: assert property (fifo_clr |=> occ == 8'h00)
    else $error("buffer not cleared");
  AST_VS_MASK: assert property (fifo_trig[2] ##1 !mask_rel |=> fifo_trig[2] == 1'b0)
    else $error("vertical sync passed while masked");
  AST_INDEX: assert property (index_match |-> $past(trk_pulse))
    else $error("index match without track pulse");

  COV_FIFO_FULL: cover property (cnt_q == FIFO_FULL ##1 pop);
  COV_CAP_ERR: cover property (cap2_take && cap2_st_q);
  COV_INDEX: cover property (index_match);
endmodule

// ==== testbench/pulse_source_model.sv ====
// pulse source model: tachometer, sync and remote pulse lines plus time-base taps
// assumes the bench requests pulses with a one-cycle fire vector on hclk
`timescale 1ns/1ns
module pulse_source_model
  import capture_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire pins_t fire,
  input wire logic [STAMP_W-1:0] stamp,
  output pins_t pins,
  output taps_t taps,
  output logic [STAMP_W-1:0] time_base
);
  logic [7:0] tick_q;
  logic [3:0] left_q;
  // one-cycle tap strobes at 1/2, 1/4, 1/8 and 1/128 of hclk
  assign taps.tap7 = (tick_q[6:0] == 7'h00);
  assign taps.tap3 = (tick_q[2:0] == 3'h0);
  assign taps.tap2 = (tick_q[1:0] == 2'h0);
  assign taps.tap1 = (tick_q[0] == 1'b0);
  // stamp is frozen by the bench so a captured value is known exactly
  assign time_base = stamp;
  // a requested line stays high six cycles: long enough to cross the synchroniser
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_q <= 8'h00;
      left_q <= 4'h0;
      pins <= '0;
    end else begin
      tick_q <= tick_q + 8'h01;
      if (fire != '0) begin
        pins <= fire;
        left_q <= 4'h6;
      end else if (left_q != 4'h0) begin
        left_q <= left_q - 4'h1;
        if (left_q == 4'h1) pins <= '0;
      end
    end
  end
endmodule

// ==== testbench/test_servo_signal_capture_unit.sv ====
// self-checking bench of the servo signal capture unit over ahb-lite
// assumes the pulse source model on the pin side and zero-wait slave answers
`timescale 1ns/1ns
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_count++; \
  $display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module test_servo_signal_capture_unit
  import capture_pkg::*;
;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, rd_ph = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic hreadyout, hresp, duty_sample_strobe, index_match;
  logic [31:0] hrdata;
  logic [7:0] remote_count;
  logic [STAMP_W-1:0] stamp = '0, time_base;
  logic [STAMP_W-1:0] st [0:8];
  pins_t fire = '0, pins;
  taps_t taps;
  logic [7:0] exp_q [$];
  int err_count = 0, cmp_count = 0;
  logic [7:0] rw_idx [0:6] = '{8'h46, 8'h47, 8'h48, 8'h49, 8'h55, 8'h57, 8'h68};
  logic [7:0] rw_msk [0:6] = '{8'hff, 8'hff, 8'h77, 8'h7f, 8'hff, 8'h1c, 8'hbf};
  logic [7:0] rv;

  servo_signal_capture_unit dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pins(pins), .taps(taps),
    .time_base(time_base), .duty_sample_strobe(duty_sample_strobe),
    .index_match(index_match), .remote_count(remote_count));
  pulse_source_model src (.hclk(hclk), .hresetn(hresetn), .fire(fire), .stamp(stamp),
    .pins(pins), .taps(taps), .time_base(time_base));

  // ****************************************
  // clock, bus master and result watcher
  // ****************************************
  initial begin
    forever #5 hclk = ~hclk;
  end
  // one single transfer; a read notes its expected byte for the watcher
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {22'h0, idx, 2'b00};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    rd_ph <= !w;
    if (!w) exp_q.push_back(d);
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd_ph <= 1'b0;
  endtask
  // read data is taken at the edge that ends the data phase
  always @(posedge hclk) begin
    if (rd_ph && hreadyout === 1'b1 && exp_q.size() > 0) `CHK(hrdata, {24'h0, exp_q.pop_front()})
  end
  // pulse chosen lines with a frozen stamp, then let the capture settle
  task automatic pulse(input pins_t p, input logic [STAMP_W-1:0] s);
    stamp <= s;
    fire <= p;
    @(posedge hclk);
    fire <= '0;
    repeat (14) @(posedge hclk);
  endtask
  task automatic end_of_test();
    $display("errors %0d, comparisons %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // a hang ends the run as a mismatch
  initial begin
    repeat (20000) @(posedge hclk);
    err_count++;
    end_of_test();
  end

  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    void'($urandom(66));
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    // reset value, then random write and readback of every writable field
    for (int i = 0; i < 7; i++) begin
      rv = 8'($urandom()) & rw_msk[i];
      bus(1'b0, rw_idx[i], 8'h00);
      bus(1'b1, rw_idx[i], rv);
      bus(1'b0, rw_idx[i], rv);
      bus(1'b1, rw_idx[i], 8'h00);
    end
    bus(1'b1, 8'h60, 8'hff);
    bus(1'b0, 8'h60, 8'h00);
    // a disabled source leaves the buffer empty
    pulse(pins_t'(7'h04), 18'h00000);
    bus(1'b0, 8'h4a, 8'h00);
    // nine captures into eight places; entries come back in arrival order
    bus(1'b1, 8'h46, 8'h10);
    for (int i = 0; i < 9; i++) begin
      st[i] = 18'($urandom());
      pulse(pins_t'(7'h04), st[i]);
    end
    bus(1'b0, 8'h4a, 8'hff);
    for (int i = 0; i < 8; i++) begin
      bus(1'b0, 8'h4b, st[i][7:0]);
      bus(1'b0, 8'h4c, st[i][15:8]);
      bus(1'b0, 8'h4d, {6'h10, st[i][17:16]});
    end
    bus(1'b0, 8'h4a, 8'h00);
    pulse(pins_t'(7'h04), 18'h00001);
    bus(1'b1, 8'h52, 8'h01);
    bus(1'b0, 8'h4a, 8'h00);
    // drum phase monitor sets and is reset by a one-shot write
    pulse(pins_t'(7'h10), 18'h00002);
    bus(1'b0, 8'h57, 8'h20);
    bus(1'b1, 8'h57, 8'h20);
    bus(1'b0, 8'h57, 8'h00);
    // drum speed into the first timestamp, status and its clear
    bus(1'b1, 8'h46, 8'h40);
    st[0] = 18'($urandom());
    pulse(pins_t'(7'h20), st[0]);
    bus(1'b0, 8'h4e, st[0][7:0]);
    bus(1'b0, 8'h4f, st[0][15:8]);
    bus(1'b0, 8'h52, 8'h40);
    bus(1'b1, 8'h52, 8'h20);
    bus(1'b0, 8'h52, 8'h00);
    // capstan is gated until the gate bit opens it; both edges capture
    bus(1'b1, 8'h46, 8'h80);
    pulse(pins_t'(7'h40), 18'h00003);
    bus(1'b0, 8'h52, 8'h00);
    bus(1'b1, 8'h55, 8'h10);
    st[1] = 18'($urandom());
    pulse(pins_t'(7'h40), st[1]);
    bus(1'b0, 8'h52, 8'h80);
    bus(1'b0, 8'h50, st[1][7:0]);
    bus(1'b0, 8'h51, st[1][15:8]);
    bus(1'b0, 8'h48, 8'h08);
    bus(1'b1, 8'h52, 8'h02);
    bus(1'b0, 8'h48, 8'h00);
    // outputs are looked at off the edge, once they have settled
    #1;
    `CHK(remote_count, 8'h00)
    `CHK(duty_sample_strobe, taps.tap3)
    bus(1'b1, 8'h48, 8'h40);
    repeat (5) @(posedge hclk);
    #1;
    `CHK(remote_count > 8'h00, 1'b1)
    repeat (2) @(posedge hclk);
    end_of_test();
  end
endmodule
